// >>> shared/iprs_pkg.sv
package iprs_pkg;
  // register byte offsets on the apb bus
  localparam logic [11:0] IPRS_SERIAL1_RX_OFF  = 12'h000;
  localparam logic [11:0] IPRS_SERIAL2_RX_OFF  = 12'h004;
  localparam logic [11:0] IPRS_SPI2_CLKDAT_OFF = 12'h008;
  localparam logic [11:0] IPRS_SPI2_SEL_OFF    = 12'h00c;
  localparam logic [11:0] IPRS_CAN_RX_OFF      = 12'h010;
  localparam logic [11:0] IPRS_PWM_SYNC_OFF    = 12'h014;
  localparam logic [11:0] IPRS_DTCMP1_OFF      = 12'h018;
  localparam logic [11:0] IPRS_DTCMP23_OFF     = 12'h01c;
  // field positions
  localparam int          IPRS_LO_POS          = 0;
  localparam int          IPRS_HI_POS          = 8;
  localparam int          IPRS_SEL_W           = 7;
  localparam int          IPRS_PIN_W           = 128;
  // selector codes and reset value
  localparam logic [6:0]  IPRS_SEL_GND         = 7'h00;
  localparam logic [6:0]  IPRS_SEL_COMPARATOR_ONE_OUTPUT        = 7'h01;
  localparam logic [6:0]  IPRS_SEL_PIN121      = 7'h79;
  localparam logic [6:0]  IPRS_SEL_RESET       = 7'h00;

  // the ten selector fields
  typedef struct packed {
    logic [6:0] serial1_rx_selector;
    logic [6:0] serial2_rx_selector;
    logic [6:0] spi2_clock_in_selector;
    logic [6:0] spi2_data_in_selector;
    logic [6:0] spi2_select_selector;
    logic [6:0] can_rx_selector;
    logic [6:0] pwm_sync1_selector;
    logic [6:0] deadtime_comp1_selector;
    logic [6:0] deadtime_comp2_selector;
    logic [6:0] deadtime_comp3_selector;
  } iprs_sel_type;

  // routed peripheral inputs
  typedef struct packed {
    logic serial1_rx_input;
    logic serial2_rx_input;
    logic spi2_clock_input;
    logic spi2_data_input;
    logic spi2_select_input;
    logic can_rx_input;
    logic pwm_sync1_input;
    logic deadtime_comp1_input;
    logic deadtime_comp2_input;
    logic deadtime_comp3_input;
  } iprs_route_type;

  // module state apart from the source synchronisers
  typedef struct packed {
    iprs_sel_type   sel;
    iprs_route_type route;
    logic [31:0]    prdata;
  } iprs_state_type;
endpackage

// >>> sim/iprs_input_remap_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module iprs_input_remap_monitor
  import iprs_pkg::*;
(
  // clock, reset and apb
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // routed inputs
  input wire iprs_route_type        route_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // access phase reads and address decode
  wire logic rd  = psel && penable && !pwrite;
  wire logic bad = (paddr > 12'h01c) || (paddr[1:0] != 2'h0);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_bad; psel && penable && bad |-> pslverr; endproperty
  a_err_bad: assert property (p_err_bad) else $error("no error on bad address");
  property p_err_ok; psel && penable && !bad |-> !pslverr; endproperty
  a_err_ok: assert property (p_err_ok) else $error("error on mapped address");
  property p_rd_bad; rd && bad |-> prdata == 32'h0; endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("bad address read nonzero");
  property p_rd_gap; rd |-> prdata[31:15] == 17'h0 && !prdata[7]; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("bits 15 or 7 set");
  property p_rd_single;
    rd && paddr inside {12'h000, 12'h004, 12'h00c, 12'h010} |-> prdata[15:7] == 9'h0;
  endproperty
  a_rd_single: assert property (p_rd_single) else $error("upper bits set");
  property p_rd_upper; rd && paddr inside {12'h014, 12'h018} |-> prdata[7:0] == 8'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("low byte set");
  property p_reset; $rose(rst_b) |-> (route_out == '0) [*3]; endproperty
  a_reset: assert property (p_reset) else $error("route high after reset");
endmodule
bind iprs_input_remap iprs_input_remap_monitor mon_u (.sys_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .route_out);
`default_nettype wire

// >>> sim/iprs_input_remap_tb.sv
`timescale 1ns/100ps
`default_nettype none
module iprs_input_remap_tb;
  import iprs_pkg::*;
  localparam logic [127:0] PV = ~128'h20; // code 5 has no pin
  localparam int CODES[5] = '{0, 1, 5, 121, 127};
  // drive, observe and model state
  logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, step = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, cmp, er;
  logic [127:0] pins;
  iprs_route_type route_out;
  int error_cnt = 0, samples_checked = 0, i, mdl[8] = '{default: 0};
  int msk[8] = '{32'h7f, 32'h7f, 32'h7f7f, 32'h7f, 32'h7f, 32'h7f00, 32'h7f00, 32'h7f7f};
  int rg[10] = '{0, 1, 2, 2, 3, 4, 5, 6, 7, 7};
  int hi[10] = '{0, 0, 8, 0, 0, 0, 8, 8, 0, 8};
  always #10 sys_clk = ~sys_clk;
  iprs_input_remap #(.PIN_VALID(PV)) dut_u (.sys_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .remappable_pin(pins),
    .comparator_one_output(cmp), .route_out);
  iprs_pin_model far_u (.sys_clk, .step, .pins, .cmp);
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one apb transfer, one idle edge after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      error_cnt++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wrc(input int r, input logic [31:0] wd, input logic [3:0] s);
    int lm;
    lm = {16'h0, {8{s[1]}}, {8{s[0]}}};
    apb(1'b1, 12'(r * 4), wd, s);
    mdl[r] = ((mdl[r] & ~lm) | (wd & lm)) & msk[r];
    chk("write_err", 32'h0, {31'h0, er});
  endtask
  task automatic rdc(input int r);
    apb(1'b0, 12'(r * 4), 32'h0, 4'h0);
    chk("read_data", mdl[r], rd);
  endtask
  // new pad levels, settle, then every route against the model
  task automatic rt();
    logic [9:0] v;
    int s;
    step <= 1'b1;
    @(posedge sys_clk);
    step <= 1'b0;
    repeat (5) @(posedge sys_clk);
    for (int j = 0; j < 10; j++) begin
      s = (mdl[rg[j]] >> hi[j]) & 32'h7f;
      v[9 - j] = (s == 0) ? 1'b0 : (s == 1) ? cmp : pins[s] & PV[s];
    end
    chk("route", {22'h0, v}, {22'h0, route_out});
  endtask
  initial begin
    d = $urandom(32'hd25a);
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    // reset values
    for (i = 0; i < 8; i++) rdc(i);
    rt();
    $display("test reset done");
    // boundary codes in every field, unimplemented bits written high
    foreach (CODES[k]) begin
      for (i = 0; i < 8; i++) wrc(i, {17'h1ffff, 7'(CODES[k]), 1'b1, 7'(CODES[k])}, 4'hf);
      rt();
      for (i = 0; i < 8; i++) rdc(i);
    end
    $display("test codes done");
    // random fields and strobes, routes follow each write
    repeat (30) begin
      i = $urandom_range(7);
      wrc(i, $urandom, 4'($urandom_range(15)));
      rdc(i);
      rt();
    end
    $display("test random done");
    // unmapped and misaligned places refused, nothing changes
    apb(1'b1, 12'h020, 32'h7f7f, 4'hf);
    chk("err_unmapped", 32'h1, {31'h0, er});
    apb(1'b1, 12'h006, 32'h7f7f, 4'hf);
    chk("err_misaligned", 32'h1, {31'h0, er});
    apb(1'b0, 12'h021, 32'h0, 4'h0);
    chk("read_unmapped", 32'h0, rd);
    for (i = 0; i < 8; i++) rdc(i);
    $display("test refused done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> sim/iprs_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module iprs_pin_model (
  // clock and request for new levels
  input  wire logic         sys_clk,
  input  wire logic         step,
  // pad levels and comparator
  output logic      [127:0] pins,
  output logic              cmp
);
  logic [128:0] lvl_ff = 129'h1_5a5a_0f0f_3c3c_9669_c3c3_a5a5_f00f_1234;
  // levels move only on request so routes can settle before a check
  always @(posedge sys_clk) begin
    if (step) begin
      lvl_ff <= {lvl_ff[127:0], lvl_ff[128]} ^ {lvl_ff[0], lvl_ff[128:1]} ^ 129'h1;
    end
  end
  assign pins = lvl_ff[127:0];
  assign cmp  = lvl_ff[128];
endmodule
`default_nettype wire

// >>> verilog/iprs_input_remap.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1: seven-bit selector continuously routes chosen source
// RULE2: code zero drives constant low
// RULE3: code one selects first comparator output
// RULE4: code 1111001 selects input-only pin 121
// RULE5: all fields clear to zero at reset
// RULE6: single low selector, bits 15-7 read zero
// RULE7: dual selectors at 14-8, 6-0; 15,7 zero
// RULE8: upper-only selector, low byte reads zero
// RULE9: selector drives first serial receive input
// RULE10: selector drives second serial receive input
// RULE11: upper shared selector drives spi2 clock
// RULE12: lower shared selector drives spi2 data
// RULE13: dedicated selector drives spi2 slave select
// RULE14: dedicated selector drives can receive input
// RULE15: upper selector drives pwm sync input
// RULE16: upper selector drives deadtime compensation one
// RULE17: last register lower drives deadtime compensation two
// RULE18: last register upper drives deadtime compensation three
// RULE19: other codes map through pin table, else low
// RULE20: selectors read/write, routing follows next cycle
module iprs_input_remap
  import iprs_pkg::*;
#(
  parameter logic [IPRS_PIN_W-1:0] PIN_VALID = {IPRS_PIN_W{1'b1}}
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // sources
  input  wire logic [IPRS_PIN_W-1:0] remappable_pin,
  input  wire logic                  comparator_one_output,
  // routed peripheral inputs
  output iprs_route_type             route_out
);

  iprs_state_type state_ff;
  iprs_state_type nxt_state;
  logic [IPRS_PIN_W-1:0] pin_s1_ff;
  logic [IPRS_PIN_W-1:0] pin_s2_ff;
  logic                  cmp_s1_ff;
  logic                  cmp_s2_ff;
  logic                  wr_en;
  logic                  rd_en;
  logic                  addr_ok;

  // picks the source for one selector code
  // code zero is the ground source and code one the comparator; neither goes through the pin table
  // code 121 always reaches the input-only pin, whatever the table says
  // every other code reaches its pin only where the table marks it present
  // a code with no pin behind it gives a steady low, never a floating level
  // the function is shared by all ten routes so every input decodes the same way
  function automatic logic pick(input logic [6:0] code,
                                input logic [IPRS_PIN_W-1:0] pins,
                                input logic cmp);
    logic res;
    res = 1'b0;
    if (code == IPRS_SEL_GND) begin
      res = 1'b0;                                    // RULE2
    end else if (code == IPRS_SEL_COMPARATOR_ONE_OUTPUT) begin
      res = cmp;                                     // RULE3
    end else if (code == IPRS_SEL_PIN121) begin
      res = pins[IPRS_SEL_PIN121];                   // RULE4
    end else if (PIN_VALID[code]) begin
      res = pins[code];                              // RULE19
    end else begin
      res = 1'b0;                                    // RULE19
    end
    return res;
  endfunction

  // builds a register image from an upper and a lower field
  function automatic logic [31:0] pack2(input logic [6:0] hi, input logic [6:0] lo);
    return {16'h0000, 1'b0, hi, 1'b0, lo};           // RULE7
  endfunction

  // two-flop synchronisers for pin and comparator sources
  // pins and the comparator change with no regard to sys_clk
  // only the second stage feeds the routes, so a metastable first stage never spreads
  // cost: a pin level reaches its route three edges later
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= remappable_pin;
      pin_s2_ff <= pin_s1_ff;
      cmp_s1_ff <= comparator_one_output;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // bus decode: zero wait state, unmapped or misaligned gives slverr
  // writes land at the access edge, when psel, penable and pwrite stand together
  // reads capture their word at the setup edge, so prdata is settled in the access phase
  // a refused write leaves every selector as it was
  // a read of a hole or a misaligned place returns zero
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= IPRS_DTCMP23_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // next state: register writes, read data capture, routing
  // everything holds unless a write, a read setup or a new source level moves it
  always_comb begin
    nxt_state = state_ff;

    // lane 0 writes: low fields at bits 6-0, bit 7 is dropped by the slice
    if (wr_en && pstrb[0]) begin                     // RULE20
      // first serial receive selector, bits 15-7 never stored
      if (paddr == IPRS_SERIAL1_RX_OFF) begin
        nxt_state.sel.serial1_rx_selector =
          pwdata[IPRS_LO_POS +: IPRS_SEL_W];         // RULE6
      // second serial receive selector
      end else if (paddr == IPRS_SERIAL2_RX_OFF) begin
        nxt_state.sel.serial2_rx_selector =
          pwdata[IPRS_LO_POS +: IPRS_SEL_W];         // RULE6
      // spi2 data selector, low half of the shared word
      end else if (paddr == IPRS_SPI2_CLKDAT_OFF) begin
        nxt_state.sel.spi2_data_in_selector =
          pwdata[IPRS_LO_POS +: IPRS_SEL_W];         // RULE7
      // spi2 slave select selector
      end else if (paddr == IPRS_SPI2_SEL_OFF) begin
        nxt_state.sel.spi2_select_selector =
          pwdata[IPRS_LO_POS +: IPRS_SEL_W];         // RULE6
      // can receive selector
      end else if (paddr == IPRS_CAN_RX_OFF) begin
        nxt_state.sel.can_rx_selector =
          pwdata[IPRS_LO_POS +: IPRS_SEL_W];         // RULE6
      // deadtime compensation two, low half of the last word
      end else if (paddr == IPRS_DTCMP23_OFF) begin
        nxt_state.sel.deadtime_comp2_selector =
          pwdata[IPRS_LO_POS +: IPRS_SEL_W];         // RULE7
      end
    end

    // lane 1 writes: high fields at bits 14-8, bit 15 is dropped by the slice
    if (wr_en && pstrb[1]) begin                     // RULE20
      // spi2 clock selector, high half of the shared word
      if (paddr == IPRS_SPI2_CLKDAT_OFF) begin
        nxt_state.sel.spi2_clock_in_selector =
          pwdata[IPRS_HI_POS +: IPRS_SEL_W];         // RULE7
      // pwm sync selector, its low byte has no storage
      end else if (paddr == IPRS_PWM_SYNC_OFF) begin
        nxt_state.sel.pwm_sync1_selector =
          pwdata[IPRS_HI_POS +: IPRS_SEL_W];         // RULE8
      // deadtime compensation one, its low byte has no storage
      end else if (paddr == IPRS_DTCMP1_OFF) begin
        nxt_state.sel.deadtime_comp1_selector =
          pwdata[IPRS_HI_POS +: IPRS_SEL_W];         // RULE8
      // deadtime compensation three, high half of the last word
      end else if (paddr == IPRS_DTCMP23_OFF) begin
        nxt_state.sel.deadtime_comp3_selector =
          pwdata[IPRS_HI_POS +: IPRS_SEL_W];         // RULE7
      end
    end

    // read data captured in setup, so it stands through the access phase
    // unimplemented bits are built as zero constants, never read from storage
    if (rd_en) begin
      // single low selector words
      if (paddr == IPRS_SERIAL1_RX_OFF) begin
        nxt_state.prdata = pack2(7'h00,
                                 state_ff.sel.serial1_rx_selector);      // RULE6
      end else if (paddr == IPRS_SERIAL2_RX_OFF) begin
        nxt_state.prdata = pack2(7'h00,
                                 state_ff.sel.serial2_rx_selector);      // RULE6
      // shared spi2 word, both halves
      end else if (paddr == IPRS_SPI2_CLKDAT_OFF) begin
        nxt_state.prdata = pack2(state_ff.sel.spi2_clock_in_selector,
                                 state_ff.sel.spi2_data_in_selector);    // RULE7
      // more single low selector words
      end else if (paddr == IPRS_SPI2_SEL_OFF) begin
        nxt_state.prdata = pack2(7'h00,
                                 state_ff.sel.spi2_select_selector);     // RULE6
      end else if (paddr == IPRS_CAN_RX_OFF) begin
        nxt_state.prdata = pack2(7'h00,
                                 state_ff.sel.can_rx_selector);          // RULE6
      // upper-only words, low byte reads zero
      end else if (paddr == IPRS_PWM_SYNC_OFF) begin
        nxt_state.prdata = pack2(state_ff.sel.pwm_sync1_selector,
                                 7'h00);                                 // RULE8
      end else if (paddr == IPRS_DTCMP1_OFF) begin
        nxt_state.prdata = pack2(state_ff.sel.deadtime_comp1_selector,
                                 7'h00);                                 // RULE8
      // last word, both deadtime halves
      end else if (paddr == IPRS_DTCMP23_OFF) begin
        nxt_state.prdata = pack2(state_ff.sel.deadtime_comp3_selector,
                                 state_ff.sel.deadtime_comp2_selector);  // RULE7
      // holes and misaligned places read zero
      end else begin
        nxt_state.prdata = 32'h0000_0000;
      end
    end

    // routing of each peripheral input from its selector
    // each route uses the stored selector, so a write moves it one edge later
    // only synchronised source levels are used

    // first serial receive input
    nxt_state.route.serial1_rx_input =
      pick(state_ff.sel.serial1_rx_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE9

    // second serial receive input
    nxt_state.route.serial2_rx_input =
      pick(state_ff.sel.serial2_rx_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE10

    // spi2 clock input
    nxt_state.route.spi2_clock_input =
      pick(state_ff.sel.spi2_clock_in_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE11

    // spi2 data input
    nxt_state.route.spi2_data_input =
      pick(state_ff.sel.spi2_data_in_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE12

    // spi2 slave select input
    nxt_state.route.spi2_select_input =
      pick(state_ff.sel.spi2_select_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE13

    // can receive input
    nxt_state.route.can_rx_input =
      pick(state_ff.sel.can_rx_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE14

    // pwm synchronisation input
    nxt_state.route.pwm_sync1_input =
      pick(state_ff.sel.pwm_sync1_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE15

    // deadtime compensation input one
    nxt_state.route.deadtime_comp1_input =
      pick(state_ff.sel.deadtime_comp1_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE16

    // deadtime compensation input two
    nxt_state.route.deadtime_comp2_input =
      pick(state_ff.sel.deadtime_comp2_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE17

    // deadtime compensation input three
    nxt_state.route.deadtime_comp3_input =
      pick(state_ff.sel.deadtime_comp3_selector,
           pin_s2_ff,
           cmp_s2_ff);                               // RULE18
  end

  // state register, everything clear at reset
  // clear selectors give the ground source, so every route starts low
  // prdata clears too, so a read before any setup shows zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '0;                                // RULE5
    end else begin
      state_ff <= nxt_state;                         // RULE1
    end
  end

  // outputs
  assign prdata    = state_ff.prdata;
  assign route_out = state_ff.route;

endmodule
`default_nettype wire
